// ### mag_threshold_detector.sv
// magnetic threshold event detector: registers, combination, latch, interrupt routing
//
// Notes on behaviour
// - latch off: event flag follows the live detection result each sample.
// - latch on: event flag holds until the source register is read.
// - logic select 0: all enabled axes at or below threshold.
// - logic select 1: any enabled axis at or above threshold.
// - axis enable bits include or exclude each axis from detection.
// - wake-include bit passes the event flag to auto-sleep/wake.
// - no threshold interrupt unless interrupt enable is 1.
// - route bit 0 selects pin two, 1 selects pin one; ORed.
// - thresholds are unsigned 15-bit, high byte 7 bits, low byte 8.
// - raw bit 0: compare offset-corrected samples.
// - event-active reads 1 while the debounce count is reached at the sample, or latched.
// - per-axis event bits for X, Y and Z in the source register.
// - per-axis polarity bit: 0 positive, 1 negative.
// - axis event and polarity read zero while that axis is disabled.
// - debounce mode 1 clears counter when condition is false.
// - debounce mode 0 decrements counter when false, stopping at zero.
// - debounce mode is top bit of X high byte; Y, Z top bits zero.
// - event set when counter reaches the count; counter never exceeds it.
// - counter steps once per magnetic sample period.
`timescale 1ns/1ps
`default_nettype none
module mag_threshold_detector (
	input  wire  logic                        core_clk_i,
	input  wire  logic                        rst_n_i,
	input  wire  logic [7:0]                  reg_addr_i,
	input  wire  logic [7:0]                  reg_wdata_i,
	input  wire  logic                        reg_wr_i,
	input  wire  logic                        reg_rd_i,
	output logic       [7:0]                  reg_rdata_o,
	input  wire  logic                        sample_tick_i,
	input  wire  mag_threshold_pkg::mag_in_t  mag_in_i,
	input  wire  logic                        raw_mode_i,
	input  wire  logic [7:0]                  ths_count_i,
	input  wire  logic                        other_irq_one_i,
	input  wire  logic                        other_irq_two_i,
	output logic                              irq_pin_one_o,
	output logic                              irq_pin_two_o,
	output logic                              wake_event_o
);
	import mag_threshold_pkg::*;

	// =====================================================
	// declarations
	cfg_t                cfg;
	cfg_t                next_cfg;
	logic [THR_HI_W-1:0] thr_hi      [AXES];
	logic [THR_HI_W-1:0] next_thr_hi [AXES];
	logic [7:0]          thr_lo      [AXES];
	logic [7:0]          next_thr_lo [AXES];
	logic                dbnc_mode;
	logic                next_dbnc_mode;
	src_t                src;
	src_t                next_src;
	src_t                live_src;
	logic [7:0]          rdata;
	logic [7:0]          next_rdata;
	logic                irq_one;
	logic                irq_two;
	logic                wake;
	logic                next_irq_one;
	logic                next_irq_two;
	logic                next_wake;
	logic [AXES-1:0]     above;
	logic [AXES-1:0]     below;
	logic [AXES-1:0]     negative;
	logic [AXES-1:0]     axis_en;
	logic [AXES-1:0]     axis_hit;
	logic                det_cond;
	logic                reached;
	logic                rd_src;
	logic                flag_out;

	// =====================================================
	// address decode
	function automatic logic sel(input logic [7:0] addr, input logic [7:0] target);
		sel = addr == target;
	endfunction

	assign rd_src  = reg_rd_i && sel(reg_addr_i, ADDR_SOURCE);
	assign axis_en = {cfg.en_z, cfg.en_y, cfg.en_x};

	// =====================================================
	// per-axis comparators
	genvar g;
	generate
		for (g = 0; g < AXES; g++) begin : g_axis
			mag_axis_compare u_cmp (
				.axis_i     (mag_in_i[g]),
				.raw_mode_i (raw_mode_i),
				.thr_i      ({thr_hi[g], thr_lo[g]}),
				.above_o    (above[g]),
				.below_o    (below[g]),
				.negative_o (negative[g])
			);
		end
	endgenerate

	// =====================================================
	// combination of axis results
	always_comb begin
		if (cfg.or_sel) begin
			axis_hit = axis_en & above;
			det_cond = |axis_hit;
		end else begin
			axis_hit = axis_en & below;
			det_cond = (axis_en != '0) && ((below | ~axis_en) == '1);
		end
	end

	// =====================================================
	// debounce
	mag_debounce #(
		.CNT_W (CNT_W)
	) u_dbnc (
		.core_clk_i   (core_clk_i),
		.rst_n_i      (rst_n_i),
		.tick_i       (sample_tick_i),
		.cond_i       (det_cond),
		.clear_mode_i (dbnc_mode),
		.limit_i      (ths_count_i),
		.count_o      (),
		.reached_o    (reached)
	);

	// =====================================================
	// configuration and threshold registers
	always_comb begin
		next_cfg       = cfg;
		next_dbnc_mode = dbnc_mode;
		next_thr_hi    = thr_hi;
		next_thr_lo    = thr_lo;
		if (reg_wr_i) begin
			if (sel(reg_addr_i, ADDR_CONFIG)) begin
				next_cfg = cfg_t'(reg_wdata_i);
			end
			if (sel(reg_addr_i, ADDR_X_HIGH)) begin
				next_dbnc_mode = reg_wdata_i[DBNC_MODE_BIT];
			end
			for (int i = 0; i < AXES; i++) begin
				if (sel(reg_addr_i, 8'(ADDR_X_HIGH + 8'(i) * AXIS_STRIDE))) begin
					next_thr_hi[i] = reg_wdata_i[THR_HI_W-1:0];
				end
				if (sel(reg_addr_i, 8'(ADDR_X_LOW + 8'(i) * AXIS_STRIDE))) begin
					next_thr_lo[i] = reg_wdata_i;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg       <= CFG_RESET;
			dbnc_mode <= DBNC_RESET;
			for (int i = 0; i < AXES; i++) begin
				thr_hi[i] <= THR_HI_RESET;
				thr_lo[i] <= THR_LO_RESET;
			end
		end else begin
			cfg       <= next_cfg;
			dbnc_mode <= next_dbnc_mode;
			thr_hi    <= next_thr_hi;
			thr_lo    <= next_thr_lo;
		end
	end

	// =====================================================
	// source register and latch
	always_comb begin
		live_src              = SRC_RESET;
		live_src.event_active = 1'b1;
		live_src.x.evt        = axis_hit[0];
		live_src.y.evt        = axis_hit[1];
		live_src.z.evt        = axis_hit[2];
		live_src.x.pol        = axis_hit[0] && negative[0];
		live_src.y.pol        = axis_hit[1] && negative[1];
		live_src.z.pol        = axis_hit[2] && negative[2];
		next_src              = src;
		if (cfg.latch_en) begin
			if (rd_src) begin
				next_src = SRC_RESET;
			end
			if (reached) begin
				next_src = next_src | live_src;
			end
		end else if (sample_tick_i) begin
			next_src = reached ? live_src : SRC_RESET;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src <= SRC_RESET;
		end else begin
			src <= next_src;
		end
	end

	// =====================================================
	// read data, interrupt and wake outputs
	always_comb begin
		next_rdata = rdata;
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_CONFIG: next_rdata = cfg;
				ADDR_SOURCE: begin
					next_rdata = {src.event_active, 1'b0,
						src.z & {2{cfg.en_z}},
						src.y & {2{cfg.en_y}},
						src.x & {2{cfg.en_x}}};
				end
				ADDR_X_HIGH: next_rdata = {dbnc_mode, thr_hi[0]};
				ADDR_X_LOW:  next_rdata = thr_lo[0];
				ADDR_Y_HIGH: next_rdata = {1'b0, thr_hi[1]};
				ADDR_Y_LOW:  next_rdata = thr_lo[1];
				ADDR_Z_HIGH: next_rdata = {1'b0, thr_hi[2]};
				ADDR_Z_LOW:  next_rdata = thr_lo[2];
				default:     next_rdata = BYTE_ZERO;
			endcase
		end
		flag_out     = cfg.int_en && src.event_active;
		next_irq_one = other_irq_one_i || (flag_out && cfg.route_one);
		next_irq_two = other_irq_two_i || (flag_out && !cfg.route_one);
		next_wake    = cfg.wake_en && src.event_active;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata   <= BYTE_ZERO;
			irq_one <= 1'b0;
			irq_two <= 1'b0;
			wake    <= 1'b0;
		end else begin
			rdata   <= next_rdata;
			irq_one <= next_irq_one;
			irq_two <= next_irq_two;
			wake    <= next_wake;
		end
	end

	assign reg_rdata_o   = rdata;
	assign irq_pin_one_o = irq_one;
	assign irq_pin_two_o = irq_two;
	assign wake_event_o  = wake;

	// =====================================================
	// checks
	a_live_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		sample_tick_i && !cfg.latch_en |=> src.event_active == $past(reached))
		else $error("unlatched flag does not follow detection");

	a_latch_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cfg.latch_en && src.event_active && !rd_src |=> src.event_active)
		else $error("latched flag lost without a read");

	a_read_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cfg.latch_en && rd_src && !reached |=> src == SRC_RESET)
		else $error("source read did not clear latched flags");

	a_and_logic: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!cfg.or_sel && det_cond |-> ((below | ~axis_en) == '1) && axis_en != '0)
		else $error("and combination wrong");

	a_or_logic: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cfg.or_sel |-> det_cond == |(axis_en & above))
		else $error("or combination wrong");

	a_axis_mask: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		rd_src && !cfg.en_x |=> reg_rdata_o[1:0] == 2'b00)
		else $error("disabled axis bits not zero");

	a_irq_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!cfg.int_en && !other_irq_one_i && !other_irq_two_i
		|=> !irq_pin_one_o && !irq_pin_two_o)
		else $error("interrupt raised while disabled");

	a_irq_route: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cfg.int_en && src.event_active
		|=> (irq_pin_one_o == $past(cfg.route_one || other_irq_one_i))
		&& (irq_pin_two_o == $past(!cfg.route_one || other_irq_two_i)))
		else $error("interrupt routed to wrong pin");

	a_wake_path: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		1'b1 |=> wake_event_o == $past(cfg.wake_en && src.event_active))
		else $error("wake flag mismatch");

	a_high_top_bits: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		reg_rd_i && (reg_addr_i == ADDR_Y_HIGH || reg_addr_i == ADDR_Z_HIGH)
		|=> !reg_rdata_o[DBNC_MODE_BIT])
		else $error("unused top bit reads one");

	a_no_tick_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!sample_tick_i && !rd_src |=> src == $past(src))
		else $error("source changed without a sample tick");

	a_pol_sign: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!cfg.latch_en && reached && axis_hit[0] |=> src.x.pol == $past(negative[0]))
		else $error("polarity does not follow sign");

	a_evt_x: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!cfg.latch_en && sample_tick_i |=> src.x.evt == $past(reached && axis_hit[0]))
		else $error("axis event bit wrong");

	a_dis_axis: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!cfg.latch_en && sample_tick_i && !cfg.en_y |=> !src.y.evt && !src.y.pol)
		else $error("disabled axis raised a flag");

	a_limit_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		sample_tick_i && det_cond && ths_count_i == BYTE_ZERO |-> reached)
		else $error("zero count did not fire at once");

	a_cond_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!det_cond |-> !reached)
		else $error("event fired without condition");

	a_mode_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		reg_wr_i && reg_addr_i == ADDR_X_HIGH |=> dbnc_mode == $past(reg_wdata_i[DBNC_MODE_BIT]))
		else $error("debounce mode bit not stored");

	a_thr_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		reg_wr_i && reg_addr_i == ADDR_Z_LOW |=> thr_lo[2] == $past(reg_wdata_i))
		else $error("threshold low byte not stored");

	a_rdata_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!reg_rd_i |=> reg_rdata_o == $past(reg_rdata_o))
		else $error("read data changed without a read");

	a_latch_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cfg.latch_en && reached |=> src.event_active)
		else $error("latched event not set");

	a_hit_masked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(axis_hit & ~axis_en) == '0)
		else $error("disabled axis counted as hit");
endmodule
`default_nettype wire

// ### mag_threshold_pkg.sv
// shared constants, field layouts and carrier types of the magnetic threshold detector
package mag_threshold_pkg;
	localparam int AXES     = 3;
	localparam int SAMPLE_W = 16;
	localparam int THR_W    = 15;
	localparam int THR_HI_W = 7;
	localparam int CNT_W    = 8;

	// register map
	localparam logic [7:0] ADDR_CONFIG = 8'h52;
	localparam logic [7:0] ADDR_SOURCE = 8'h53;
	localparam logic [7:0] ADDR_X_HIGH = 8'h54;
	localparam logic [7:0] ADDR_X_LOW  = 8'h55;
	localparam logic [7:0] ADDR_Y_HIGH = 8'h56;
	localparam logic [7:0] ADDR_Y_LOW  = 8'h57;
	localparam logic [7:0] ADDR_Z_HIGH = 8'h58;
	localparam logic [7:0] ADDR_Z_LOW  = 8'h59;
	localparam logic [7:0] AXIS_STRIDE = 8'h02;

	// field positions and reset values
	localparam int              DBNC_MODE_BIT = 7;
	localparam logic [7:0]      BYTE_ZERO     = 8'h00;
	localparam logic [THR_HI_W-1:0] THR_HI_RESET = 7'h00;
	localparam logic [7:0]      THR_LO_RESET  = 8'h00;
	localparam logic            DBNC_RESET    = 1'b0;

	typedef struct packed {
		logic latch_en;
		logic or_sel;
		logic en_z;
		logic en_y;
		logic en_x;
		logic wake_en;
		logic int_en;
		logic route_one;
	} cfg_t;
	localparam cfg_t CFG_RESET = 8'h00;

	typedef struct packed {
		logic evt;
		logic pol;
	} axis_flag_t;

	typedef struct packed {
		logic       event_active;
		logic       spare;
		axis_flag_t z;
		axis_flag_t y;
		axis_flag_t x;
	} src_t;
	localparam src_t SRC_RESET = 8'h00;

	typedef struct packed {
		logic signed [SAMPLE_W-1:0] sample;
		logic signed [THR_W-1:0]    offset;
	} axis_in_t;

	typedef axis_in_t [AXES-1:0] mag_in_t;
	typedef logic [THR_W-1:0] thr_t;
endpackage

// ### mag_axis_compare.sv
// one axis: offset correction, magnitude and threshold comparison
`timescale 1ns/1ps
`default_nettype none
module mag_axis_compare (
	input  wire  mag_threshold_pkg::axis_in_t axis_i,
	input  wire  logic                        raw_mode_i,
	input  wire  mag_threshold_pkg::thr_t     thr_i,
	output logic                              above_o,
	output logic                              below_o,
	output logic                              negative_o
);
	import mag_threshold_pkg::*;

	logic signed [SAMPLE_W:0] corrected;
	logic        [SAMPLE_W:0] magnitude;
	logic        [SAMPLE_W:0] thr_wide;

	// =====================================================
	// correction and compare
	always_comb begin
		if (raw_mode_i) begin
			corrected = {axis_i.sample[SAMPLE_W-1], axis_i.sample};
		end else begin
			corrected = {axis_i.sample[SAMPLE_W-1], axis_i.sample}
				- {{2{axis_i.offset[THR_W-1]}}, axis_i.offset};
		end
		magnitude  = corrected[SAMPLE_W] ? (SAMPLE_W+1)'(-corrected) : (SAMPLE_W+1)'(corrected);
		thr_wide   = {2'b00, thr_i};
		above_o    = magnitude >= thr_wide;
		below_o    = magnitude <= thr_wide;
		negative_o = corrected[SAMPLE_W];
	end
endmodule
`default_nettype wire

// ### mag_debounce.sv
// debounce counter of the threshold detector
`timescale 1ns/1ps
`default_nettype none
module mag_debounce #(
	parameter int CNT_W = 8
) (
	input  wire  logic             core_clk_i,
	input  wire  logic             rst_n_i,
	input  wire  logic             tick_i,
	input  wire  logic             cond_i,
	input  wire  logic             clear_mode_i,
	input  wire  logic [CNT_W-1:0] limit_i,
	output logic       [CNT_W-1:0] count_o,
	output logic                   reached_o
);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;

	// =====================================================
	// counter
	always_comb begin
		next_count = count;
		if (tick_i) begin
			if (cond_i) begin
				if (count < limit_i) begin
					next_count = count + 1'b1;
				end else begin
					next_count = limit_i;
				end
			end else if (clear_mode_i) begin
				next_count = '0;
			end else if (count > limit_i) begin
				next_count = limit_i;
			end else if (count != '0) begin
				next_count = count - 1'b1;
			end
		end
		reached_o = tick_i && cond_i && (next_count == limit_i);
		count_o   = count;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// =====================================================
	// checks
	a_dbnc_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		tick_i && !cond_i && clear_mode_i |=> count == '0)
		else $error("debounce counter not cleared");
	a_dbnc_step_down: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		tick_i && !cond_i && !clear_mode_i && count != '0 && count <= limit_i
		|=> count == $past(count) - 1'b1)
		else $error("debounce counter did not decrement");
	a_dbnc_cap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		tick_i |=> count <= $past(limit_i))
		else $error("debounce counter above limit");
endmodule
`default_nettype wire

// ### mag_host_model.sv
// host model driving the register port with one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module mag_host_model (
	input  wire  logic       core_clk_i,
	output logic       [7:0] reg_addr_o,
	output logic       [7:0] reg_wdata_o,
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	input  wire  logic [7:0] reg_rdata_i
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end
	// ==========================================
	// bus cycles
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(posedge core_clk_i);
		#1;
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
		reg_addr_o = ~a;
	endtask
	// one read pulse; the edge that takes a read of the source register clears latched flags
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		#1;
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(posedge core_clk_i);
		#1;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rdata_i;
	endtask
endmodule
`default_nettype wire

// ### magnetic_threshold_detector_tb.sv
// self-checking testbench of the magnetic threshold detector
`timescale 1ns/1ps
`default_nettype none
module magnetic_threshold_detector_tb;
	import mag_threshold_pkg::*;
	logic       core_clk_i, rst_n_i, sample_tick_i, raw_mode_i, oth1, oth2, irq1, irq2, wake, wr, rd_s, c;
	logic [7:0] addr, wdata, rdata, ths_count, rd;
	mag_in_t    mag;
	cfg_t       cfg;
	src_t       es;
	thr_t       thr [AXES];
	int         miscompares, n_tests, cycles, ref_cnt;

	mag_host_model host (.core_clk_i(core_clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
		.reg_rd_o(rd_s), .reg_rdata_i(rdata));
	mag_threshold_detector dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .sample_tick_i(sample_tick_i),
		.mag_in_i(mag), .raw_mode_i(raw_mode_i), .ths_count_i(ths_count), .other_irq_one_i(oth1),
		.other_irq_two_i(oth2), .irq_pin_one_o(irq1), .irq_pin_two_o(irq2), .wake_event_o(wake));

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end
	// ==========================================
	// checking and expectations
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic src_t exp_src(input cfg_t k);
		logic [2:0] en, hit, pol;
		int v, a;
		en = {k.en_z, k.en_y, k.en_x};
		for (int i = 0; i < AXES; i++) begin
			v = raw_mode_i ? int'(mag[i].sample) : int'(mag[i].sample) - int'(mag[i].offset);
			a = v < 0 ? -v : v;
			hit[i] = en[i] && (k.or_sel ? a >= int'(thr[i]) : a <= int'(thr[i]));
			pol[i] = hit[i] && v < 0;
		end
		if (k.or_sel ? |hit : (en != 3'h0 && hit == en))
			return {2'b10, hit[2], pol[2], hit[1], pol[1], hit[0], pol[0]};
		return SRC_RESET;
	endfunction
	task automatic tick();
		@(posedge core_clk_i);
		#1;
		sample_tick_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		sample_tick_i = 1'b0;
	endtask
	task automatic set_thr(input logic dm);
		for (int i = 0; i < AXES; i++) begin
			host.write_reg(8'(ADDR_X_HIGH + AXIS_STRIDE * i), {dm && i == 0, thr[i][14:8]});
			host.write_reg(8'(ADDR_X_LOW + AXIS_STRIDE * i), thr[i][7:0]);
		end
	endtask
	// ==========================================
	// main sequence
	initial begin
		{rst_n_i, sample_tick_i, raw_mode_i, oth1, oth2} = 5'h00;
		ths_count = 8'h00;
		mag = '0;
		void'($urandom(32'ha9be7f0c));
		repeat (3) @(posedge core_clk_i);
		#1;
		rst_n_i = 1'b1;
		for (int a = 8'h52; a < 8'h5b; a++) begin
			host.read_reg(8'(a), rd);
			check("reset value", rd, 8'h00);
		end
		for (int i = 0; i < AXES; i++) begin
			host.write_reg(8'(ADDR_X_HIGH + AXIS_STRIDE * i), 8'hff);
			host.read_reg(8'(ADDR_X_HIGH + AXIS_STRIDE * i), rd);
			check("high byte", rd, i == 0 ? 8'hff : 8'h7f);
		end
		host.write_reg(ADDR_SOURCE, 8'hff);
		host.read_reg(ADDR_SOURCE, rd);
		check("source write", rd, 8'h00);
		// random compares, unlatched, count limit zero
		for (int n = 0; n < 60; n++) begin
			cfg = cfg_t'(8'($urandom) & 8'h7f);
			for (int i = 0; i < AXES; i++) begin
				thr[i] = 15'($urandom_range(12000));
				mag[i].sample = 16'($urandom_range(16000)) - 16'd8000;
				mag[i].offset = 15'($urandom_range(8000)) - 15'd4000;
			end
			{raw_mode_i, oth1, oth2} = 3'($urandom);
			set_thr(1'b0);
			host.write_reg(ADDR_CONFIG, cfg);
			host.read_reg(ADDR_CONFIG, rd);
			check("config", rd, cfg);
			es = exp_src(cfg);
			tick();
			host.read_reg(ADDR_SOURCE, rd);
			check("source", rd, es);
			check("pins", {5'h00, irq1, irq2, wake}, {5'h00, (cfg.int_en && cfg.route_one && es.event_active) | oth1,
				(cfg.int_en && !cfg.route_one && es.event_active) | oth2, cfg.wake_en && es.event_active});
		end
		// debounce in both modes, limit three
		thr[0] = 15'd100;
		raw_mode_i = 1'b0;
		mag[0].offset = 15'h0000;
		ths_count = 8'h03;
		ref_cnt = 0;
		for (int m = 0; m < 2; m++) begin
			set_thr(1'(m));
			host.write_reg(ADDR_CONFIG, 8'h48);
			for (int k = 0; k < 24; k++) begin
				c = k < 6 ? 1'(6'b011011 >> k) : 1'($urandom_range(1));
				if (c)
					ref_cnt = ref_cnt < 3 ? ref_cnt + 1 : 3;
				else if (m == 1)
					ref_cnt = 0;
				else if (ref_cnt > 0)
					ref_cnt--;
				mag[0].sample = c ? 16'sd500 : 16'sd0;
				tick();
				host.read_reg(ADDR_SOURCE, rd);
				check("debounce event", {7'h00, rd[7]}, {7'h00, c && ref_cnt == 3});
			end
		end
		// latched events held until the source is read
		ths_count = 8'h00;
		host.write_reg(ADDR_CONFIG, 8'hc8);
		for (int p = 0; p < 2; p++) begin
			mag[0].sample = p == 0 ? 16'sd500 : -16'sd500;
			tick();
			mag[0].sample = 16'sd0;
			tick();
			host.read_reg(ADDR_SOURCE, rd);
			check("latched source", rd, {7'h41, 1'(p)});
			host.read_reg(ADDR_SOURCE, rd);
			check("cleared source", rd, 8'h00);
		end
		final_report();
	end
endmodule
`default_nettype wire
